// ### inc/srqm_pkg.sv
package srqm_pkg;
   // -------------------------------------------------------------------------
   // Register map, as Avalon word indexes
   // -------------------------------------------------------------------------
   localparam logic [2:0] REG_CMD = 3'h0;
   localparam logic [2:0] REG_ADDR = 3'h1;
   localparam logic [2:0] REG_WDATA = 3'h2;
   localparam logic [2:0] REG_RDATA = 3'h3;
   localparam logic [2:0] REG_STATUS = 3'h4;
   localparam logic [2:0] REG_CFG = 3'h5;
   localparam int ST_BUSY = 0;
   localparam int ST_SECURE = 1;
   localparam int ST_QUERY = 2;
   localparam int ST_FLOCK = 3;
   localparam int ST_REFUSED = 4;
   localparam int ST_MISMATCH = 5;
   localparam int ST_PROT = 6;
   localparam int CFG_BYTE = 0;
   localparam int CFG_PROT = 1;
   // -------------------------------------------------------------------------
   // Operations and flash command codes
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      SRQM_OP_NONE = 4'h0, SRQM_OP_READ = 4'h1, SRQM_OP_WRITE = 4'h2, SRQM_OP_ENTER = 4'h3,
      SRQM_OP_EXIT = 4'h4, SRQM_OP_QUERY = 4'h5, SRQM_OP_RESET = 4'h6, SRQM_OP_LOCKRD = 4'h7,
      SRQM_OP_HWRST = 4'h8
   } srqm_op_t;
   localparam logic [7:0] CODE_UNLK1 = 8'haa;
   localparam logic [7:0] CODE_UNLK2 = 8'h55;
   localparam logic [7:0] CODE_ENTER = 8'h88;
   localparam logic [7:0] CODE_EXIT = 8'h90;
   localparam logic [7:0] CODE_EXIT2 = 8'h00;
   localparam logic [7:0] CODE_AUTOSEL = 8'h90;
   localparam logic [7:0] CODE_QUERY = 8'h98;
   localparam logic [7:0] CODE_RESET = 8'hf0;
   localparam logic [7:0] CODE_BYPASS = 8'h20;
   localparam logic [20:0] W_UNLK1 = 21'h000555;
   localparam logic [20:0] B_UNLK1 = 21'h000aaa;
   localparam logic [20:0] W_UNLK2 = 21'h0002aa;
   localparam logic [20:0] B_UNLK2 = 21'h000555;
   localparam logic [20:0] W_QRY = 21'h000055;
   localparam logic [20:0] B_QRY = 21'h0000aa;
   localparam logic [20:0] W_LOCKIND = 21'h000003;
   localparam logic [20:0] B_LOCKIND = 21'h000006;
   localparam logic [20:0] QRY_MASK_W = 21'h00007f;
   localparam int LOCK_BIT = 7;
   // -------------------------------------------------------------------------
   // Secure region geometry and timing
   // -------------------------------------------------------------------------
   localparam logic [20:0] REGION_BYTES = 21'h000100;
   localparam logic [20:0] REGION_WORDS = 21'h000080;
   localparam logic [20:0] SERIAL_BYTES = 21'h000010;
   localparam logic [20:0] SERIAL_WORDS = 21'h000008;
   localparam logic [20:0] REGION_BASE = 21'h0f8000;
   localparam int CLK_NS = 50;
   localparam int T_ACC_NS = 70;
   localparam int T_WP_NS = 35;
   localparam int T_RP_NS = 500;
   localparam int CYC_ACC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_WP = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_RP = (T_RP_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### rtl/srqm_host.sv
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
//Contract
//- Locking starts with the three-cycle enter sequence.
//- Exit the secure region before touching the remaining array.
//- Query mode is entered by 98h at 55h word or AAh byte.
//- In word mode query reads keep address bit seven and up zero.
//- Query mode lasts until the reset command.
module srqm_host #(
   parameter int ADDR_W = 21
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [2:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic [ADDR_W-1:0] FL_ADDR,
   input wire logic [15:0] FL_DQ_I,
   output logic [15:0] FL_DQ_O,
   output logic FL_DQ_OE_N,
   output logic FL_CE_N,
   output logic FL_OE_N,
   output logic FL_WE_N,
   output logic FL_RESET_N,
   output logic FL_BYTE_N
);
   if (ADDR_W != 21) begin : g_chk_addr
      $error("srqm_host serves a 21-bit flash address only.");
   end
   if (srqm_pkg::CYC_RP > 15 || srqm_pkg::CYC_ACC > 15) begin : g_chk_cnt
      $error("srqm_host timing counts exceed the 4-bit counter.");
   end

   // -------------------------------------------------------------------------
   // Sequence table
   // -------------------------------------------------------------------------
   // Returns {last, is_read, address, data} for one bus cycle of an operation.
   function automatic logic [38:0] seq_step(input logic [3:0] op, input logic [2:0] idx,
                                            input logic bm, input logic [20:0] a,
                                            input logic [15:0] d);
      logic [20:0] u1;
      logic [20:0] u2;
      u1 = bm ? srqm_pkg::B_UNLK1 : srqm_pkg::W_UNLK1;
      u2 = bm ? srqm_pkg::B_UNLK2 : srqm_pkg::W_UNLK2;
      seq_step = {2'b10, 21'h000000, 8'h00, srqm_pkg::CODE_RESET};
      unique case ({op, idx})
         {srqm_pkg::SRQM_OP_READ, 3'h0}: seq_step = {2'b11, a, 16'h0000};
         {srqm_pkg::SRQM_OP_WRITE, 3'h0}: seq_step = {2'b10, a, d};
         {srqm_pkg::SRQM_OP_ENTER, 3'h0}, {srqm_pkg::SRQM_OP_EXIT, 3'h0},
         {srqm_pkg::SRQM_OP_LOCKRD, 3'h0}: seq_step = {2'b00, u1, 8'h00, srqm_pkg::CODE_UNLK1};
         {srqm_pkg::SRQM_OP_ENTER, 3'h1}, {srqm_pkg::SRQM_OP_EXIT, 3'h1},
         {srqm_pkg::SRQM_OP_LOCKRD, 3'h1}: seq_step = {2'b00, u2, 8'h00, srqm_pkg::CODE_UNLK2};
         {srqm_pkg::SRQM_OP_ENTER, 3'h2}: seq_step = {2'b10, u1, 8'h00, srqm_pkg::CODE_ENTER};
         {srqm_pkg::SRQM_OP_EXIT, 3'h2}: seq_step = {2'b00, u1, 8'h00, srqm_pkg::CODE_EXIT};
         {srqm_pkg::SRQM_OP_EXIT, 3'h3}: seq_step = {2'b10, 21'h000000, 8'h00, srqm_pkg::CODE_EXIT2};
         {srqm_pkg::SRQM_OP_LOCKRD, 3'h2}: seq_step = {2'b00, u1, 8'h00, srqm_pkg::CODE_AUTOSEL};
         {srqm_pkg::SRQM_OP_LOCKRD, 3'h3}:
            seq_step = {2'b01, bm ? srqm_pkg::B_LOCKIND : srqm_pkg::W_LOCKIND, 16'h0000};
         {srqm_pkg::SRQM_OP_QUERY, 3'h0}:
            seq_step = {2'b10, bm ? srqm_pkg::B_QRY : srqm_pkg::W_QRY, 8'h00, srqm_pkg::CODE_QUERY};
         default: seq_step = {2'b10, 21'h000000, 8'h00, srqm_pkg::CODE_RESET};
      endcase
   endfunction

   // Expected query words; a zero also covers the alternate set and unsupported entries.
   function automatic logic [15:0] cfi_expect(input logic [6:0] wa);
      unique case (wa)
         7'h10: cfi_expect = 16'h0051;
         7'h11: cfi_expect = 16'h0052;
         7'h12: cfi_expect = 16'h0059;
         7'h13: cfi_expect = 16'h0002;
         7'h15: cfi_expect = 16'h0040;
         7'h1b: cfi_expect = 16'h0027;
         7'h1c: cfi_expect = 16'h0036;
         7'h1f: cfi_expect = 16'h0007;
         7'h21: cfi_expect = 16'h000a;
         7'h23: cfi_expect = 16'h0001;
         7'h25: cfi_expect = 16'h0004;
         default: cfi_expect = 16'h0000;
      endcase
   endfunction

   // -------------------------------------------------------------------------
   // Registers and bus slave
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      SRQM_IDLE = 3'b000, SRQM_LOAD = 3'b001, SRQM_SETUP = 3'b011, SRQM_STROBE = 3'b010,
      SRQM_HOLD = 3'b110, SRQM_HWRST = 3'b111
   } srqm_state_t;

   srqm_state_t state_ff, nxt_state;
   logic [3:0] op_ff, cnt_ff, nxt_cnt;
   logic [2:0] idx_ff, nxt_idx;
   logic [20:0] addr_ff, nxt_addr, pin_addr_ff, nxt_pin_addr;
   logic [15:0] wdata_ff, rdata_ff, dq_o_ff, nxt_dq_o;
   logic ack_ff, byte_ff, prot_ff, sec_ff, qry_ff, flock_ff, refused_ff, mism_ff;
   logic dq_oe_n_ff, nxt_dq_oe_n, ce_n_ff, nxt_ce_n, oe_n_ff, nxt_oe_n;
   logic we_n_ff, nxt_we_n, rst_n_ff, nxt_rst_n;
   logic [31:0] readdata_ff;

   wire bus_req = AVS_READ | AVS_WRITE;
   wire wr_en = AVS_WRITE & ack_ff;
   wire wr_cmd = wr_en && AVS_ADDRESS == srqm_pkg::REG_CMD;
   wire [3:0] new_op = AVS_WRITEDATA[3:0];
   wire idle = state_ff == SRQM_IDLE;

   // Region window checks for the address that software staged.
   wire [20:0] reg_size = byte_ff ? srqm_pkg::REGION_BYTES : srqm_pkg::REGION_WORDS;
   wire [20:0] ser_size = byte_ff ? srqm_pkg::SERIAL_BYTES : srqm_pkg::SERIAL_WORDS;
   wire [20:0] reg_off = addr_ff - srqm_pkg::REGION_BASE;
   wire in_region = addr_ff >= srqm_pkg::REGION_BASE && reg_off < reg_size;
   // Outside the serial words a factory-locked region is unavailable.
   wire ser_ok = !flock_ff || reg_off < ser_size;
   // Every read outside the region is refused until exit or hardware reset.
   wire rd_bad = sec_ff && !(in_region && ser_ok);
   // Locked or protected regions take no writes; unprotected ones do, except data whose low byte is 20h.
   wire wr_lock = sec_ff && (flock_ff || prot_ff || !in_region);
   wire wr_bypass = sec_ff && wdata_ff[7:0] == srqm_pkg::CODE_BYPASS;
   wire wr_bad = wr_lock || wr_bypass || qry_ff;
   wire op_known = new_op >= 4'(srqm_pkg::SRQM_OP_READ) && new_op <= 4'(srqm_pkg::SRQM_OP_HWRST);
   wire op_bad = !idle || !op_known
                 || (new_op == 4'(srqm_pkg::SRQM_OP_READ) && rd_bad)
                 || (new_op == 4'(srqm_pkg::SRQM_OP_WRITE) && wr_bad)
                 || (new_op == 4'(srqm_pkg::SRQM_OP_ENTER) && qry_ff);
   wire go = wr_cmd && !op_bad;
   wire refuse_set = wr_cmd && op_bad;

   wire [38:0] step = seq_step(op_ff, idx_ff, byte_ff, addr_ff, wdata_ff);
   wire step_last = step[38];
   wire step_rd = step[37];
   // Query reads in word mode keep address bit seven and above at zero.
   wire [20:0] step_addr = (qry_ff && !byte_ff && op_ff == 4'(srqm_pkg::SRQM_OP_READ))
                           ? (step[36:16] & srqm_pkg::QRY_MASK_W) : step[36:16];
   wire strobe_end = state_ff == SRQM_STROBE && cnt_ff == 4'h0;
   wire rd_sample = strobe_end && step_rd;
   wire seq_done = state_ff == SRQM_HOLD && step_last;
   wire [3:0] cyc_acc = 4'(srqm_pkg::CYC_ACC - 1);
   wire [3:0] cyc_wp = 4'(srqm_pkg::CYC_WP - 1);
   wire [3:0] cyc_rp = 4'(srqm_pkg::CYC_RP - 1);

   // Query data sits on the low byte; byte addresses are halved to word offsets.
   wire [15:0] rd_word = (qry_ff || byte_ff) ? {8'h00, FL_DQ_I[7:0]} : FL_DQ_I;
   wire [6:0] q_wa = byte_ff ? step_addr[7:1] : step_addr[6:0];
   wire q_chk = qry_ff && op_ff == 4'(srqm_pkg::SRQM_OP_READ) && q_wa >= 7'h10 && q_wa <= 7'h26;
   wire mism_set = rd_sample && q_chk && rd_word != cfi_expect(q_wa);
   wire lock_cap = rd_sample && op_ff == 4'(srqm_pkg::SRQM_OP_LOCKRD);
   wire st_wr = wr_en && AVS_ADDRESS == srqm_pkg::REG_STATUS;

   wire [31:0] status_word = {25'h0000000, prot_ff, mism_ff, refused_ff, flock_ff, qry_ff,
                              sec_ff, !idle};
   logic [31:0] rd_mux;
   always_comb begin
      unique case (AVS_ADDRESS)
         srqm_pkg::REG_CMD: rd_mux = {28'h0000000, op_ff};
         srqm_pkg::REG_ADDR: rd_mux = {11'h000, addr_ff};
         srqm_pkg::REG_WDATA: rd_mux = {16'h0000, wdata_ff};
         srqm_pkg::REG_RDATA: rd_mux = {16'h0000, rdata_ff};
         srqm_pkg::REG_STATUS: rd_mux = status_word;
         srqm_pkg::REG_CFG: rd_mux = {30'h00000000, prot_ff, byte_ff};
         default: rd_mux = 32'h00000000;
      endcase
   end

   assign AVS_WAITREQUEST = bus_req & ~ack_ff;
   assign AVS_READDATA = readdata_ff;

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack_ff <= 1'b0;
         readdata_ff <= 32'h00000000;
         addr_ff <= 21'h000000;
         wdata_ff <= 16'h0000;
         byte_ff <= 1'b0;
         prot_ff <= 1'b0;
      end else begin
         ack_ff <= bus_req & ~ack_ff;
         if (AVS_READ && !ack_ff) begin
            readdata_ff <= rd_mux;
         end
         if (wr_en && idle && AVS_ADDRESS == srqm_pkg::REG_ADDR) begin
            addr_ff <= AVS_WRITEDATA[20:0];
         end
         if (wr_en && idle && AVS_ADDRESS == srqm_pkg::REG_WDATA) begin
            wdata_ff <= AVS_WRITEDATA[15:0];
         end
         if (wr_en && idle && AVS_ADDRESS == srqm_pkg::REG_CFG) begin
            byte_ff <= AVS_WRITEDATA[srqm_pkg::CFG_BYTE];
            // Protection is one-way: software can set the mirror, never clear it.
            prot_ff <= prot_ff | AVS_WRITEDATA[srqm_pkg::CFG_PROT];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Mode tracking
   // -------------------------------------------------------------------------
   // The sticky flags let a new event win over a same-cycle clear.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sec_ff <= 1'b0;
         qry_ff <= 1'b0;
         flock_ff <= 1'b0;
         refused_ff <= 1'b0;
         mism_ff <= 1'b0;
         rdata_ff <= 16'h0000;
         op_ff <= 4'h0;
      end else begin
         refused_ff <= refuse_set | (refused_ff & ~(st_wr & AVS_WRITEDATA[srqm_pkg::ST_REFUSED]));
         mism_ff <= mism_set | (mism_ff & ~(st_wr & AVS_WRITEDATA[srqm_pkg::ST_MISMATCH]));
         if (go) begin
            op_ff <= new_op;
         end
         if (rd_sample) begin
            rdata_ff <= rd_word;
         end
         if (lock_cap) begin
            flock_ff <= FL_DQ_I[srqm_pkg::LOCK_BIT];
         end
         if (seq_done && op_ff == 4'(srqm_pkg::SRQM_OP_ENTER)) begin
            sec_ff <= 1'b1;
         end else if (seq_done && op_ff == 4'(srqm_pkg::SRQM_OP_EXIT)) begin
            sec_ff <= 1'b0;
         end
         if (seq_done && op_ff == 4'(srqm_pkg::SRQM_OP_QUERY)) begin
            qry_ff <= 1'b1;
         end else if (seq_done && op_ff == 4'(srqm_pkg::SRQM_OP_RESET)) begin
            qry_ff <= 1'b0;
         end
         if (state_ff == SRQM_HWRST && cnt_ff == 4'h0) begin
            sec_ff <= 1'b0;
            qry_ff <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Bus cycle engine
   // -------------------------------------------------------------------------
   // Address and data settle one cycle before the strobe, so setup never races it.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_idx = idx_ff;
      nxt_pin_addr = pin_addr_ff;
      nxt_dq_o = dq_o_ff;
      nxt_dq_oe_n = dq_oe_n_ff;
      nxt_ce_n = ce_n_ff;
      nxt_oe_n = oe_n_ff;
      nxt_we_n = we_n_ff;
      nxt_rst_n = rst_n_ff;
      unique case (state_ff)
         SRQM_IDLE: begin
            nxt_idx = 3'h0;
            if (go && new_op == 4'(srqm_pkg::SRQM_OP_HWRST)) begin
               nxt_state = SRQM_HWRST;
               nxt_cnt = cyc_rp;
               nxt_rst_n = 1'b0;
            end else if (go) begin
               nxt_state = SRQM_LOAD;
            end
         end
         SRQM_LOAD: begin
            nxt_pin_addr = step_addr;
            nxt_dq_o = step[15:0];
            nxt_dq_oe_n = step_rd;
            nxt_ce_n = 1'b0;
            nxt_state = SRQM_SETUP;
         end
         SRQM_SETUP: begin
            nxt_oe_n = !step_rd;
            nxt_we_n = step_rd;
            nxt_cnt = step_rd ? cyc_acc : cyc_wp;
            nxt_state = SRQM_STROBE;
         end
         SRQM_STROBE: begin
            if (cnt_ff == 4'h0) begin
               nxt_oe_n = 1'b1;
               nxt_we_n = 1'b1;
               nxt_state = SRQM_HOLD;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         SRQM_HOLD: begin
            nxt_ce_n = 1'b1;
            nxt_dq_oe_n = 1'b1;
            nxt_idx = idx_ff + 3'h1;
            nxt_state = step_last ? SRQM_IDLE : SRQM_LOAD;
         end
         SRQM_HWRST: begin
            if (cnt_ff == 4'h0) begin
               nxt_rst_n = 1'b1;
               nxt_state = SRQM_IDLE;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         default: nxt_state = SRQM_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_ff <= SRQM_IDLE;
         cnt_ff <= 4'h0;
         idx_ff <= 3'h0;
         pin_addr_ff <= 21'h000000;
         dq_o_ff <= 16'h0000;
         dq_oe_n_ff <= 1'b1;
         ce_n_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         we_n_ff <= 1'b1;
         rst_n_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         idx_ff <= nxt_idx;
         pin_addr_ff <= nxt_pin_addr;
         dq_o_ff <= nxt_dq_o;
         dq_oe_n_ff <= nxt_dq_oe_n;
         ce_n_ff <= nxt_ce_n;
         oe_n_ff <= nxt_oe_n;
         we_n_ff <= nxt_we_n;
         rst_n_ff <= nxt_rst_n;
      end
   end

   assign FL_ADDR = pin_addr_ff;
   assign FL_DQ_O = dq_o_ff;
   assign FL_DQ_OE_N = dq_oe_n_ff;
   assign FL_CE_N = ce_n_ff;
   assign FL_OE_N = oe_n_ff;
   assign FL_WE_N = we_n_ff;
   assign FL_RESET_N = rst_n_ff;
   assign FL_BYTE_N = !byte_ff;
endmodule // srqm_host

// ### test/srqm_flash_model.sv
`timescale 1ns/10ps
// ----
// Behavioural flash device seen from its pins
// ----
module srqm_flash_model (
   input wire logic [20:0] addr,
   input wire logic [15:0] dq_o,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_n,
   input wire logic byte_n,
   input wire logic lock,
   output logic [15:0] dq_i
);
   localparam logic [15:0] QT [13] = '{16'h1051, 16'h1152, 16'h1259, 16'h1302, 16'h1400,
      16'h1540, 16'h1b27, 16'h1c36, 16'h1f07, 16'h2000, 16'h210a, 16'h2301, 16'h2504};
   logic [15:0] sec [128];
   logic [15:0] val, last_q;
   logic [7:0] d1, d2;
   logic sec_ff, qry_ff, asel_ff, exit_ff;
   wire [20:0] wa = byte_n ? addr : addr >> 1;
   wire unl = d2 == 8'haa && d1 == 8'h55;
   wire in_reg = wa[20:7] == 14'h1f00;
   initial begin
      for (int i = 0; i < 128; i++) sec[i] = 16'hc000 | 16'(i);
      {sec_ff, qry_ff, asel_ff, exit_ff, d1, d2, last_q} = '0;
   end
   always @(posedge we_n or negedge reset_n) begin
      if (!reset_n) begin
         {sec_ff, qry_ff, asel_ff, exit_ff} <= '0;
      end else if (!ce_n) begin
         if (sec_ff && in_reg && !lock) sec[wa[6:0]] <= dq_o;
         if (dq_o[7:0] == 8'h98 && wa[7:0] == 8'h55) qry_ff <= 1'b1;
         if (dq_o[7:0] == 8'hf0) {qry_ff, asel_ff} <= '0;
         if (unl && dq_o[7:0] == 8'h88) sec_ff <= 1'b1;
         if (unl && dq_o[7:0] == 8'h90 && sec_ff) exit_ff <= 1'b1;
         if (unl && dq_o[7:0] == 8'h90 && !sec_ff) asel_ff <= 1'b1;
         if (exit_ff && dq_o[7:0] == 8'h00) {sec_ff, exit_ff} <= '0;
         d2 <= d1;
         d1 <= dq_o[7:0];
      end
   end
   always_comb begin
      val = addr[15:0] ^ 16'h5a5a;
      if (qry_ff) begin
         val = '0;
         for (int i = 0; i < 13; i++) if (QT[i][15:8] == wa[7:0]) val = {8'h00, QT[i][7:0]};
      end else if (asel_ff && wa[1:0] == 2'h3) val = {8'h00, lock, 7'h03};
      else if (sec_ff && in_reg) val = (lock && wa[6:3] != 0) ? 16'hffff : sec[wa[6:0]];
   end
   // A released bus shows the inverse of its last value, so stale data never matches.
   always @(posedge oe_n) last_q <= val;
   assign dq_i = (!ce_n && !oe_n) ? val : ~last_q;
endmodule // srqm_flash_model

// ### test/srqm_host_chk.sv
`timescale 1ns/10ps
// ----
// Port checker
// ----
module srqm_host_chk #(
   parameter int ADDR_W = 21
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [2:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic [ADDR_W-1:0] FL_ADDR,
   input wire logic [15:0] FL_DQ_I,
   input wire logic [15:0] FL_DQ_O,
   input wire logic FL_DQ_OE_N,
   input wire logic FL_CE_N,
   input wire logic FL_OE_N,
   input wire logic FL_WE_N,
   input wire logic FL_RESET_N,
   input wire logic FL_BYTE_N
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   logic q_ff;
   wire wr98 = !FL_WE_N && FL_DQ_O[7:0] == 8'h98;
   wire nxt_q = FL_RESET_N && (wr98 || (q_ff && !(!FL_WE_N && FL_DQ_O[7:0] == 8'hf0)));
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) q_ff <= 1'b0;
      else q_ff <= nxt_q;
   end
   wait_one_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("waitrequest held past one cycle");
   unmapped_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 3'h5
      |-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
   write_drive_a: assert property (!FL_WE_N |-> !FL_DQ_OE_N && !FL_CE_N && FL_OE_N)
      else $error("write strobe without drive");
   read_float_a: assert property (!FL_OE_N |-> FL_DQ_OE_N && !FL_CE_N)
      else $error("read strobe while driving");
   read_len_a: assert property ($fell(FL_OE_N) |=> !FL_OE_N ##1 FL_OE_N)
      else $error("read strobe length");
   write_len_a: assert property ($fell(FL_WE_N) |=> FL_WE_N) else $error("write strobe length");
   addr_hold_a: assert property (!FL_CE_N && !$fell(FL_CE_N) |-> $stable(FL_ADDR))
      else $error("address moved in cycle");
   query_addr_a: assert property (wr98 |-> FL_ADDR == (FL_BYTE_N ? 'h55 : 'haa))
      else $error("query command address");
   query_high_a: assert property (q_ff && !FL_OE_N && FL_BYTE_N |-> FL_ADDR[ADDR_W-1:7] == '0)
      else $error("query read high address bits");
   enter_addr_a: assert property (!FL_WE_N && FL_DQ_O[7:0] == 8'h88
      |-> FL_ADDR == (FL_BYTE_N ? 'h555 : 'haaa)) else $error("enter command address");
   hw_reset_a: assert property ($fell(FL_RESET_N) |-> ##9 !FL_RESET_N ##1 FL_RESET_N)
      else $error("hardware reset pulse length");
   cover property (q_ff && !FL_OE_N);
   cover property ($fell(FL_RESET_N));
   cover property (!FL_WE_N && FL_DQ_O[7:0] == 8'h88);
endmodule // srqm_host_chk
bind srqm_host srqm_host_chk #(.ADDR_W(ADDR_W)) srqm_host_chk_inst (.SYS_CLK, .RST_N,
   .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST,
   .FL_ADDR, .FL_DQ_I, .FL_DQ_O, .FL_DQ_OE_N, .FL_CE_N, .FL_OE_N, .FL_WE_N, .FL_RESET_N,
   .FL_BYTE_N);

// ### test/srqm_host_tb.sv
`timescale 1ns/10ps
// ----
// Testbench
// ----
module srqm_host_tb;
   localparam logic [15:0] QT [13] = '{16'h1051, 16'h1152, 16'h1259, 16'h1302, 16'h1400,
      16'h1540, 16'h1b27, 16'h1c36, 16'h1f07, 16'h2000, 16'h210a, 16'h2301, 16'h2504};
   logic SYS_CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, lock;
   logic FL_DQ_OE_N, FL_CE_N, FL_OE_N, FL_WE_N, FL_RESET_N, FL_BYTE_N;
   logic [2:0] AVS_ADDRESS;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA, rdv;
   logic [20:0] FL_ADDR;
   logic [15:0] FL_DQ_I, FL_DQ_O, rnd;
   int fail_count, num_checks;
   srqm_host srqm_host_inst (.SYS_CLK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
      .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .FL_ADDR, .FL_DQ_I, .FL_DQ_O,
      .FL_DQ_OE_N, .FL_CE_N, .FL_OE_N, .FL_WE_N, .FL_RESET_N, .FL_BYTE_N);
   srqm_flash_model srqm_flash_model_inst (.addr(FL_ADDR), .dq_o(FL_DQ_O), .ce_n(FL_CE_N),
      .oe_n(FL_OE_N), .we_n(FL_WE_N), .reset_n(FL_RESET_N), .byte_n(FL_BYTE_N), .lock(lock),
      .dq_i(FL_DQ_I));
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [15:0] arr(input logic [20:0] a);
      return a[15:0] ^ 16'h5a5a;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Waitrequest and read data are taken at the edge, before that edge's updates land.
   task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge SYS_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      for (int n = 0; n < 20 && !done; n++) begin
         @(posedge SYS_CLK);
         done = AVS_WAITREQUEST === 1'b0;
         rdv = AVS_READDATA;
      end
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      if (!done) chk(32'h0, 32'h1);
      if (!done) report_and_stop();
   endtask
   task automatic op(input srqm_pkg::srqm_op_t o, input logic [20:0] a, input logic [15:0] d);
      int n;
      n = 0;
      av(1'b1, srqm_pkg::REG_ADDR, 32'(a));
      av(1'b1, srqm_pkg::REG_WDATA, 32'(d));
      av(1'b1, srqm_pkg::REG_CMD, 32'(o));
      do begin
         av(1'b0, srqm_pkg::REG_STATUS, 32'h0);
         n++;
      end while (rdv[srqm_pkg::ST_BUSY] !== 1'b0 && n < 40);
      if (rdv[srqm_pkg::ST_BUSY] !== 1'b0) chk(32'h0, 32'h1);
      if (rdv[srqm_pkg::ST_BUSY] !== 1'b0) report_and_stop();
   endtask
   task automatic st(input int b, input logic e);
      av(1'b0, srqm_pkg::REG_STATUS, 32'h0);
      chk(32'(rdv[b]), 32'(e));
   endtask
   task automatic refd(input logic e);
      st(srqm_pkg::ST_REFUSED, e);
      av(1'b1, srqm_pkg::REG_STATUS, 32'h30);
   endtask
   task automatic rd(input logic [20:0] a, input logic [15:0] e);
      op(srqm_pkg::SRQM_OP_READ, a, 16'h0);
      av(1'b0, srqm_pkg::REG_RDATA, 32'h0);
      chk(rdv, 32'(e));
   endtask
   initial begin
      SYS_CLK = 1'b0;
      forever #25 SYS_CLK = ~SYS_CLK;
   end
   initial begin
      {RST_N, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, fail_count, num_checks} = '0;
      lock = 1'b1;
      rnd = 16'h0038;
      repeat (2) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      av(1'b0, srqm_pkg::REG_STATUS, 32'h0);
      chk(rdv, 32'h0);
      av(1'b0, srqm_pkg::REG_CFG, 32'h0);
      chk(rdv, 32'h0);
      av(1'b1, 3'h6, 32'hffff_ffff);
      av(1'b0, 3'h6, 32'h0);
      chk(rdv, 32'h0);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         rd({5'h00, rnd}, arr({5'h00, rnd}));
      end
      $display("test registers and array done");
      op(srqm_pkg::SRQM_OP_QUERY, 21'h0, 16'h0);
      st(srqm_pkg::ST_QUERY, 1'b1);
      op(srqm_pkg::SRQM_OP_ENTER, 21'h0, 16'h0);
      refd(1'b1);
      foreach (QT[i]) rd({13'h0, QT[i][15:8]}, {8'h00, QT[i][7:0]});
      st(srqm_pkg::ST_MISMATCH, 1'b0);
      op(srqm_pkg::SRQM_OP_RESET, 21'h0, 16'h0);
      st(srqm_pkg::ST_QUERY, 1'b0);
      rd(21'h000010, arr(21'h000010));
      op(srqm_pkg::SRQM_OP_WRITE, 21'h000555, 16'h00aa);
      op(srqm_pkg::SRQM_OP_WRITE, 21'h0002aa, 16'h0055);
      op(srqm_pkg::SRQM_OP_WRITE, 21'h000555, 16'h0090);
      op(srqm_pkg::SRQM_OP_QUERY, 21'h0, 16'h0);
      rd(21'h0fff91, 16'h0052);
      op(srqm_pkg::SRQM_OP_RESET, 21'h0, 16'h0);
      av(1'b1, srqm_pkg::REG_CFG, 32'h1);
      op(srqm_pkg::SRQM_OP_QUERY, 21'h0, 16'h0);
      rd(21'h000024, 16'h0059);
      rd(21'h00004a, 16'h0004);
      op(srqm_pkg::SRQM_OP_RESET, 21'h0, 16'h0);
      av(1'b1, srqm_pkg::REG_CFG, 32'h0);
      $display("test query done");
      op(srqm_pkg::SRQM_OP_LOCKRD, 21'h0, 16'h0);
      st(srqm_pkg::ST_FLOCK, 1'b1);
      op(srqm_pkg::SRQM_OP_ENTER, 21'h0, 16'h0);
      st(srqm_pkg::ST_SECURE, 1'b1);
      rd(21'h0f8007, 16'hc007);
      op(srqm_pkg::SRQM_OP_READ, 21'h0f8008, 16'h0);
      refd(1'b1);
      op(srqm_pkg::SRQM_OP_WRITE, 21'h0f8001, {rnd[15:8], 8'h5a});
      refd(1'b1);
      op(srqm_pkg::SRQM_OP_EXIT, 21'h0, 16'h0);
      st(srqm_pkg::ST_SECURE, 1'b0);
      rd(21'h0f8007, arr(21'h0f8007));
      $display("test factory locked done");
      lock = 1'b0;
      op(srqm_pkg::SRQM_OP_LOCKRD, 21'h0, 16'h0);
      st(srqm_pkg::ST_FLOCK, 1'b0);
      op(srqm_pkg::SRQM_OP_ENTER, 21'h0, 16'h0);
      rd(21'h0f807f, 16'hc07f);
      rnd = lfsr(rnd);
      op(srqm_pkg::SRQM_OP_WRITE, 21'h0f8040, {rnd[15:8], 8'h5a});
      refd(1'b0);
      rd(21'h0f8040, {rnd[15:8], 8'h5a});
      op(srqm_pkg::SRQM_OP_WRITE, 21'h0f8041, 16'h0020);
      refd(1'b1);
      av(1'b1, srqm_pkg::REG_CFG, 32'h2);
      op(srqm_pkg::SRQM_OP_WRITE, 21'h0f8042, 16'h1234);
      refd(1'b1);
      rd(21'h0f8042, 16'hc042);
      op(srqm_pkg::SRQM_OP_HWRST, 21'h0, 16'h0);
      st(srqm_pkg::ST_SECURE, 1'b0);
      rd(21'h0f8040, arr(21'h0f8040));
      $display("test customer lockable done");
      report_and_stop();
   end
endmodule // srqm_host_tb
